// *** rtl/cmrs_defines.svh ***
// bit positions, reset values and counts of the cpu register state block
// assumes inclusion by bare name from the core
`ifndef CMRS_DEFINES_SVH
`define CMRS_DEFINES_SVH
`define CMRS_SP_IDX       3'd7
`define CMRS_EXR_T        7
`define CMRS_EXR_RSV      4'hF
`define CMRS_EXR_T_RST    1'b0
`define CMRS_EXR_LVL_RST  3'h7
`define CMRS_CCR_I        7
`define CMRS_CCR_H        5
`define CMRS_CCR_N        3
`define CMRS_CCR_Z        2
`define CMRS_CCR_V        1
`define CMRS_CCR_C        0
`define CMRS_BLOCK_STATES 2'd3
`define CMRS_PC_STEP      24'h000002
`define CMRS_PC_RST       24'h000000
`define CMRS_VEC_BASE     24'h000000
`endif

// *** rtl/cmrs_pkg.sv ***
// types of the cpu register state block
// uses nothing from the defines header
package cmrs_pkg;
  typedef enum logic [2:0] {
    CMRS_WR_BH = 3'b000,
    CMRS_WR_BL = 3'b001,
    CMRS_WR_WE = 3'b010,
    CMRS_WR_WR = 3'b011,
    CMRS_WR_WL = 3'b100
  } cmrs_wsize_t;
  typedef enum logic [1:0] {
    CMRS_SZ_B = 2'b00,
    CMRS_SZ_W = 2'b01,
    CMRS_SZ_L = 2'b10
  } cmrs_size_t;
  typedef enum logic [1:0] {
    CMRS_ALU_ADD   = 2'b00,
    CMRS_ALU_SUB   = 2'b01,
    CMRS_ALU_LOGIC = 2'b10,
    CMRS_ALU_SHIFT = 2'b11
  } cmrs_alu_op_t;
  typedef enum logic [2:0] {
    CMRS_CR_LOAD  = 3'b000,
    CMRS_CR_STORE = 3'b001,
    CMRS_CR_AND   = 3'b010,
    CMRS_CR_OR    = 3'b011,
    CMRS_CR_XOR   = 3'b100
  } cmrs_cr_op_t;
  typedef enum logic [2:0] {
    CMRS_S_IDLE = 3'b000,
    CMRS_S_RVEC = 3'b001,
    CMRS_S_PPC  = 3'b010,
    CMRS_S_PCCR = 3'b011,
    CMRS_S_PEXR = 3'b100,
    CMRS_S_VEC  = 3'b101,
    CMRS_S_MI   = 3'b110
  } cmrs_state_t;
  typedef struct packed {
    logic        en;
    logic [2:0]  idx;
    cmrs_wsize_t size;
    logic [31:0] data;
  } cmrs_wr_t;
  typedef struct packed {
    logic         en;
    cmrs_alu_op_t op;
    cmrs_size_t   size;
    logic [31:0]  a;
    logic [31:0]  b;
    logic         cin;
    logic [31:0]  res;
    logic         sc;
  } cmrs_alu_t;
  typedef struct packed {
    logic        en;
    logic        tgt_exr;
    cmrs_cr_op_t op;
    logic [7:0]  data;
  } cmrs_cr_t;
endpackage

// *** rtl/cmrs_core.sv ***
// cpu architectural state: general registers, control registers, frames
// assumes mode pins steady, memory answers each request with one ack pulse
`timescale 1ns/1ps
`include "cmrs_defines.svh"
module cmrs_core
  import cmrs_pkg::*;
#(
  parameter int ACCUMULATOR_HIGH_BITS = 10
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        mode_large,
  input  wire cmrs_wr_t    gwr,
  input  wire logic        au_en,
  input  wire logic [2:0]  au_idx,
  input  wire logic        au_dec,
  input  wire logic [2:0]  au_step,
  input  wire logic [2:0]  rd_idx,
  output logic      [31:0] rd_data,
  input  wire logic [31:0] ea_in,
  output logic      [23:0] ea_out,
  input  wire cmrs_alu_t   alu,
  output logic      [31:0] alu_res,
  input  wire cmrs_cr_t    cr,
  output logic      [7:0]  cr_rdata,
  input  wire logic        mac_clr,
  input  wire logic        mac_wr_hi,
  input  wire logic        mac_wr_lo,
  input  wire logic        mac_acc,
  input  wire logic [31:0] mac_data,
  output logic      [31:0] accumulator_high_out,
  output logic      [31:0] accumulator_low_out,
  input  wire logic        pc_ld,
  input  wire logic [23:0] pc_ld_addr,
  input  wire logic        pc_inc,
  output logic      [23:0] pc_out,
  output logic      [23:0] fetch_addr,
  input  wire logic        instr_done,
  output logic             trace_req,
  output logic             int_block,
  output logic      [7:0]  ccr_out,
  output logic      [7:0]  exr_out,
  input  wire logic        call_req,
  input  wire logic [23:0] call_target,
  input  wire logic        mi_req,
  input  wire logic        mi_call,
  input  wire logic [7:0]  mi_aa,
  input  wire logic        exc_req,
  input  wire logic [7:0]  exc_idx,
  input  wire logic        exr_valid,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_long,
  output logic      [23:0] mem_addr,
  output logic      [31:0] mem_wdata,
  output logic             busy
);
  localparam int MW = 32 + ACCUMULATOR_HIGH_BITS;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  function automatic logic [23:0] mask_addr(input logic lg, input logic [31:0] a);
    mask_addr = lg ? a[23:0] : {8'h00, a[15:0]};
  endfunction

  function automatic logic [23:0] branch_addr(input logic lg, input logic [31:0] d);
    branch_addr = lg ? d[23:0] : {8'h00, d[15:0]};
  endfunction

  logic [31:0]   gpr [8];
  logic [23:0]   pc_reg;
  logic          exr_t_reg;
  logic [2:0]    exr_lvl_reg;
  logic [7:0]    ccr_reg;
  logic [MW-1:0] mac_reg;
  logic [1:0]    blk_cnt_reg;
  cmrs_state_t   state_reg;
  cmrs_state_t   state_next;
  logic          exc_kind_reg;
  logic          exr_v_reg;
  logic          mi_call_reg;
  logic [7:0]    idx_reg;
  logic [7:0]    aa_reg;
  logic [23:0]   tgt_reg;
  logic [7:0]    exr_val;
  logic          idle_take;
  logic          exc_take;
  logic          issue;
  logic          push_issue;
  logic [31:0]   sp_step;
  logic [31:0]   sp_new;
  logic [23:0]   rd_target;
  logic [4:0]    sh;
  logic [31:0]   ah;
  logic [31:0]   bh;
  logic [32:0]   ch;
  logic [32:0]   sum33;
  logic [28:0]   half29;
  logic [31:0]   rh;
  logic [31:0]   lh;
  logic          arith;
  logic          is_add;
  logic [7:0]    cr_old;
  logic [7:0]    cr_new;

  assign exr_val    = {exr_t_reg, `CMRS_EXR_RSV, exr_lvl_reg};
  assign idle_take  = clk_en && state_reg == CMRS_S_IDLE && (exc_req || mi_req || call_req);
  assign exc_take   = clk_en && state_reg == CMRS_S_IDLE && exc_req;
  assign issue      = state_reg != CMRS_S_IDLE && !mem_req;
  assign push_issue = issue && (state_reg == CMRS_S_PPC || state_reg == CMRS_S_PCCR
                      || state_reg == CMRS_S_PEXR);
  assign sp_step    = (mode_large && state_reg == CMRS_S_PPC) ? 32'h00000004 : 32'h00000002;
  assign sp_new     = gpr[`CMRS_SP_IDX] - sp_step;
  assign rd_target  = branch_addr(mode_large, mem_rdata);

  // general registers, aliases share the same bits
  always_ff @(posedge clk)
  begin
    if (clk_en)
    begin
      if (au_en)
      begin
        if (au_dec)
          gpr[au_idx] <= gpr[au_idx] - {29'h0, au_step};
        else
          gpr[au_idx] <= gpr[au_idx] + {29'h0, au_step};
      end
      if (gwr.en)
      begin
        unique case (gwr.size)
          CMRS_WR_BH: gpr[gwr.idx][15:8]  <= gwr.data[7:0];
          CMRS_WR_BL: gpr[gwr.idx][7:0]   <= gwr.data[7:0];
          CMRS_WR_WE: gpr[gwr.idx][31:16] <= gwr.data[15:0];
          CMRS_WR_WR: gpr[gwr.idx][15:0]  <= gwr.data[15:0];
          CMRS_WR_WL: gpr[gwr.idx]        <= gwr.data;
          default:    gpr[gwr.idx]        <= gpr[gwr.idx];
        endcase
      end
      if (push_issue)
        gpr[`CMRS_SP_IDX] <= sp_new;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rd_data <= 32'h00000000;
    else if (clk_en)
      rd_data <= gpr[rd_idx];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ea_out <= 24'h000000;
    else if (clk_en)
      ea_out <= mask_addr(mode_large, ea_in);
  end

  property p_ea_mask;
    clk_en |=> ea_out == mask_addr($past(mode_large), $past(ea_in));
  endproperty
  a_ea_mask: assert property (p_ea_mask) else $error("address not masked for mode");

  // frame and vector sequencer
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      CMRS_S_IDLE:
        if (exc_req || call_req)
          state_next = (exc_req || !mi_req) ? CMRS_S_PPC : CMRS_S_MI;
        else if (mi_req)
          state_next = CMRS_S_MI;
      CMRS_S_RVEC:
        if (mem_ack)
          state_next = CMRS_S_IDLE;
      CMRS_S_PPC:
        if (mem_ack)
        begin
          if (!exc_kind_reg)
            state_next = CMRS_S_IDLE;
          else if (!mode_large)
            state_next = CMRS_S_PCCR;
          else
            state_next = exr_v_reg ? CMRS_S_PEXR : CMRS_S_VEC;
        end
      CMRS_S_PCCR:
        if (mem_ack)
          state_next = exr_v_reg ? CMRS_S_PEXR : CMRS_S_VEC;
      CMRS_S_PEXR:
        if (mem_ack)
          state_next = CMRS_S_VEC;
      CMRS_S_VEC:
        if (mem_ack)
          state_next = CMRS_S_IDLE;
      CMRS_S_MI:
        if (mem_ack)
          state_next = mi_call_reg ? CMRS_S_PPC : CMRS_S_IDLE;
      default:
        state_next = CMRS_S_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= CMRS_S_RVEC;
      busy      <= 1'b1;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      busy      <= state_next != CMRS_S_IDLE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      exc_kind_reg <= 1'b0;
      exr_v_reg    <= 1'b0;
      mi_call_reg  <= 1'b0;
      idx_reg      <= 8'h00;
      aa_reg       <= 8'h00;
      tgt_reg      <= 24'h000000;
    end
    else if (idle_take)
    begin
      exc_kind_reg <= exc_req;
      exr_v_reg    <= exr_valid;
      mi_call_reg  <= mi_call;
      idx_reg      <= exc_idx;
      aa_reg       <= mi_aa;
      tgt_reg      <= call_target;
    end
    else if (clk_en && state_reg == CMRS_S_MI && mem_ack)
      tgt_reg <= rd_target;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_long  <= 1'b0;
      mem_addr  <= 24'h000000;
      mem_wdata <= 32'h00000000;
    end
    else if (clk_en)
    begin
      if (mem_req && mem_ack)
        mem_req <= 1'b0;
      else if (issue)
      begin
        mem_req   <= 1'b1;
        mem_long  <= mode_large;
        mem_we    <= 1'b0;
        mem_wdata <= 32'h00000000;
        unique case (state_reg)
          CMRS_S_RVEC: mem_addr <= `CMRS_VEC_BASE;
          CMRS_S_PPC:
          begin
            mem_we    <= 1'b1;
            mem_addr  <= mask_addr(mode_large, sp_new);
            mem_wdata <= mode_large ? {exc_kind_reg ? ccr_reg : 8'h00, pc_reg}
                                    : {16'h0000, pc_reg[15:0]};
          end
          CMRS_S_PCCR:
          begin
            mem_we    <= 1'b1;
            mem_long  <= 1'b0;
            mem_addr  <= mask_addr(mode_large, sp_new);
            mem_wdata <= {16'h0000, ccr_reg, 8'h00};
          end
          CMRS_S_PEXR:
          begin
            mem_we    <= 1'b1;
            mem_long  <= 1'b0;
            mem_addr  <= mask_addr(mode_large, sp_new);
            mem_wdata <= {16'h0000, exr_val, 8'h00};
          end
          CMRS_S_VEC:
            mem_addr <= mode_large ? {14'h0000, idx_reg, 2'b00}
                                   : {15'h0000, idx_reg, 1'b0};
          CMRS_S_MI: mem_addr <= {16'h0000, aa_reg};
          default:   mem_addr <= 24'h000000;
        endcase
      end
    end
  end

  property p_mi_area;
    state_reg == CMRS_S_MI && mem_req |->
      mem_addr[23:8] == 16'h0000 && mem_long == mode_large && !mem_we;
  endproperty
  a_mi_area: assert property (p_mi_area) else $error("indirect operand out of area");
  property p_push_sp;
    clk_en && push_issue |=>
      mem_req && mem_we && mem_addr == mask_addr(mode_large, gpr[`CMRS_SP_IDX]);
  endproperty
  a_push_sp: assert property (p_push_sp) else $error("push not at stack pointer");

  // program counter
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pc_reg <= `CMRS_PC_RST;
    else if (clk_en)
    begin
      if (mem_ack && (state_reg == CMRS_S_RVEC || state_reg == CMRS_S_VEC))
        pc_reg <= rd_target;
      else if (mem_ack && state_reg == CMRS_S_MI && !mi_call_reg)
        pc_reg <= rd_target;
      else if (mem_ack && state_reg == CMRS_S_PPC && !exc_kind_reg)
        pc_reg <= tgt_reg;
      else if (pc_ld)
        pc_reg <= pc_ld_addr;
      else if (pc_inc)
        pc_reg <= pc_reg + `CMRS_PC_STEP;
    end
  end

  assign pc_out = pc_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      fetch_addr <= 24'h000000;
    else if (clk_en)
      fetch_addr <= mask_addr(mode_large, {8'h00, pc_reg[23:1], 1'b0});
  end

  sequence s_vec_ack;
    clk_en && mem_ack && (state_reg == CMRS_S_RVEC || state_reg == CMRS_S_VEC);
  endsequence
  property p_vec_load;
    s_vec_ack |=> pc_reg == branch_addr(mode_large, $past(mem_rdata));
  endproperty
  a_vec_load: assert property (p_vec_load) else $error("pc not loaded from vector");
  property p_fetch_even;
    clk_en |=> fetch_addr[0] == 1'b0 && fetch_addr[15:1] == $past(pc_reg[15:1]);
  endproperty
  a_fetch_even: assert property (p_fetch_even) else $error("fetch address wrong");

  // control registers
  always_comb
  begin
    cr_old = cr.tgt_exr ? exr_val : ccr_reg;
    unique case (cr.op)
      CMRS_CR_LOAD: cr_new = cr.data;
      CMRS_CR_AND:  cr_new = cr_old & cr.data;
      CMRS_CR_OR:   cr_new = cr_old | cr.data;
      CMRS_CR_XOR:  cr_new = cr_old ^ cr.data;
      default:      cr_new = cr_old;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      exr_t_reg   <= `CMRS_EXR_T_RST;
      exr_lvl_reg <= `CMRS_EXR_LVL_RST;
    end
    else if (clk_en && cr.en && cr.tgt_exr)
    begin
      exr_t_reg   <= cr_new[`CMRS_EXR_T];
      exr_lvl_reg <= cr_new[2:0];
    end
  end

  assign exr_out = exr_val;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ccr_reg[`CMRS_CCR_I] <= 1'b1;
    else if (clk_en)
    begin
      if (cr.en && !cr.tgt_exr)
        ccr_reg <= cr_new;
      if (alu.en)
      begin
        unique case (alu.op)
          CMRS_ALU_ADD, CMRS_ALU_SUB:
          begin
            ccr_reg[`CMRS_CCR_H] <= half29[28];
            ccr_reg[`CMRS_CCR_N] <= rh[31];
            ccr_reg[`CMRS_CCR_Z] <= rh == 32'h00000000;
            ccr_reg[`CMRS_CCR_V] <= is_add ? (ah[31] == bh[31] && rh[31] != ah[31])
                                           : (ah[31] != bh[31] && rh[31] != ah[31]);
            ccr_reg[`CMRS_CCR_C] <= sum33[32];
          end
          CMRS_ALU_LOGIC:
          begin
            ccr_reg[`CMRS_CCR_N] <= lh[31];
            ccr_reg[`CMRS_CCR_Z] <= lh == 32'h00000000;
            ccr_reg[`CMRS_CCR_V] <= 1'b0;
          end
          CMRS_ALU_SHIFT:
          begin
            ccr_reg[`CMRS_CCR_N] <= lh[31];
            ccr_reg[`CMRS_CCR_Z] <= lh == 32'h00000000;
            ccr_reg[`CMRS_CCR_V] <= 1'b0;
            ccr_reg[`CMRS_CCR_C] <= alu.sc;
          end
        endcase
      end
      if (exc_take)
        ccr_reg[`CMRS_CCR_I] <= 1'b1;
    end
  end

  assign ccr_out = ccr_reg;

  property p_exc_mask;
    exc_take |=> ccr_reg[`CMRS_CCR_I];
  endproperty
  a_exc_mask: assert property (p_exc_mask) else $error("mask not set at exception");
  property p_exr_rsv;
    clk_en && cr.en && cr.tgt_exr && cr.op == CMRS_CR_STORE |=>
      cr_rdata[6:3] == `CMRS_EXR_RSV;
  endproperty
  a_exr_rsv: assert property (p_exr_rsv) else $error("reserved bits not read as one");

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cr_rdata <= 8'h00;
    else if (clk_en && cr.en && cr.op == CMRS_CR_STORE)
      cr_rdata <= cr_old;
  end

  // interrupt blocking after ext control changes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      blk_cnt_reg <= 2'd0;
      int_block   <= 1'b0;
    end
    else if (clk_en)
    begin
      if (cr.en && cr.tgt_exr && cr.op != CMRS_CR_STORE)
      begin
        blk_cnt_reg <= `CMRS_BLOCK_STATES;
        int_block   <= 1'b1;
      end
      else if (blk_cnt_reg != 2'd0)
      begin
        blk_cnt_reg <= blk_cnt_reg - 2'd1;
        int_block   <= blk_cnt_reg != 2'd1;
      end
    end
  end

  sequence s_exr_mod;
    clk_en && cr.en && cr.tgt_exr && cr.op != CMRS_CR_STORE;
  endsequence
  sequence s_block3;
    int_block [*3];
  endsequence
  property p_block;
    s_exr_mod |=> s_block3;
  endproperty
  a_block: assert property (p_block) else $error("interrupts not blocked three states");
  property p_store_free;
    clk_en && cr.en && cr.op == CMRS_CR_STORE && blk_cnt_reg == 2'd0 |=> !int_block;
  endproperty
  a_store_free: assert property (p_store_free) else $error("store caused blocking");

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      trace_req <= 1'b0;
    else if (clk_en)
      trace_req <= instr_done && exr_t_reg;
  end

  property p_trace;
    clk_en && instr_done |=> trace_req == $past(exr_t_reg);
  endproperty
  a_trace: assert property (p_trace) else $error("trace request wrong");

  // flag arithmetic, operands aligned so the sign sits at bit 31
  always_comb
  begin
    unique case (alu.size)
      CMRS_SZ_B: sh = 5'd24;
      CMRS_SZ_W: sh = 5'd16;
      CMRS_SZ_L: sh = 5'd0;
      default:   sh = 5'd0;
    endcase
  end

  assign is_add = alu.op == CMRS_ALU_ADD;
  assign arith  = alu.op == CMRS_ALU_ADD || alu.op == CMRS_ALU_SUB;
  assign ah     = alu.a << sh;
  assign bh     = alu.b << sh;
  assign ch     = {32'h00000000, alu.cin} << sh;
  assign sum33  = is_add ? ({1'b0, ah} + {1'b0, bh} + ch)
                         : ({1'b0, ah} - {1'b0, bh} - ch);
  assign half29 = is_add ? ({1'b0, ah[27:0]} + {1'b0, bh[27:0]} + ch[28:0])
                         : ({1'b0, ah[27:0]} - {1'b0, bh[27:0]} - ch[28:0]);
  assign rh     = sum33[31:0];
  assign lh     = alu.res << sh;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      alu_res <= 32'h00000000;
    else if (clk_en && alu.en)
      alu_res <= arith ? (rh >> sh) : alu.res;
  end

  // multiply-accumulate
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mac_reg <= '0;
    else if (clk_en)
    begin
      if (mac_clr)
        mac_reg <= '0;
      else if (mac_acc)
        mac_reg <= mac_reg + {{ACCUMULATOR_HIGH_BITS{mac_data[31]}}, mac_data};
      else
      begin
        if (mac_wr_hi)
          mac_reg[MW-1:32] <= mac_data[ACCUMULATOR_HIGH_BITS-1:0];
        if (mac_wr_lo)
          mac_reg[31:0] <= mac_data;
      end
    end
  end

  assign accumulator_high_out = {{(32-ACCUMULATOR_HIGH_BITS){mac_reg[MW-1]}}, mac_reg[MW-1:32]};
  assign accumulator_low_out = mac_reg[31:0];

  property p_mac_sext;
    clk_en && mac_wr_hi && !mac_clr && !mac_acc |=>
      accumulator_high_out[ACCUMULATOR_HIGH_BITS-1:0] == $past(mac_data[ACCUMULATOR_HIGH_BITS-1:0])
      && accumulator_high_out[31:ACCUMULATOR_HIGH_BITS] == {(32-ACCUMULATOR_HIGH_BITS){$past(mac_data[ACCUMULATOR_HIGH_BITS-1])}};
  endproperty
  a_mac_sext: assert property (p_mac_sext) else $error("mac high word not sign extended");

endmodule

// *** verif/tb_cpu_mode_and_register_state.sv ***
// self-checking bench of the cpu register state block in both address modes
// assumes cmrs_core and cmrs_pkg; inputs change at the falling clock edge
`timescale 1ns/1ps
module tb_cpu_mode_and_register_state;
  import cmrs_pkg::*;
  logic        clk, rst_n, clk_en, mode_large, au_en, au_dec, mac_clr, mac_wr_hi, mac_wr_lo;
  logic        mac_acc, pc_ld, pc_inc, instr_done, call_req, mi_req, mi_call, exc_req;
  logic        exr_valid, mem_ack, trace_req, int_block, mem_req, mem_we, mem_long, busy;
  logic [2:0]  au_idx, au_step, rd_idx;
  logic [7:0]  mi_aa, exc_idx, cr_rdata, ccr_out, exr_out, d, ex, a8, b8;
  logic [23:0] pc_ld_addr, call_target, ea_out, pc_out, fetch_addr, mem_addr, pa, pcv, ev;
  logic [24:0] a;
  logic [31:0] rd_data, ea_in, alu_res, mac_data, accumulator_high_out, accumulator_low_out, mem_rdata, mem_wdata;
  logic [31:0] r, w, s;
  logic [41:0] mv;
  logic        wv;
  cmrs_wr_t    gwr;
  cmrs_alu_t   alu;
  cmrs_cr_t    cr;
  cmrs_cr_op_t ops [4] = '{CMRS_CR_LOAD, CMRS_CR_AND, CMRS_CR_OR, CMRS_CR_XOR};
  int          miscompares, samples_checked, nb, nt, n;

  cmrs_core u_cmrs_core (.*);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // waits for a request, answers it with one ack pulse
  task automatic ack(input logic [31:0] dd, output logic [24:0] aa, output logic [31:0] wd);
    int i;
    for (i = 0; i < 40 && mem_req !== 1'b1; i++)
      @(negedge clk);
    if (i == 40)
    begin
      miscompares++;
      report_and_stop();
    end
    else
    begin
      aa = {mem_long, mem_addr};
      wd = mem_wdata;
      wv = mem_we;
      mem_rdata = dd;
      mem_ack = 1'b1;
      @(negedge clk);
      mem_ack = 1'b0;
    end
  endtask

  task automatic wr(input logic [2:0] i, input cmrs_wsize_t sz, input logic [31:0] dd);
    gwr = '{1'b1, i, sz, dd};
    @(negedge clk);
    gwr.en = 1'b0;
    @(negedge clk);
  endtask

  task automatic rdc(input logic [2:0] i, input logic [31:0] e);
    rd_idx = i;
    @(negedge clk);
    chk("rd_data", e, rd_data);
  endtask

  // control op, then counts cycles of interrupt blocking
  task automatic crop(input logic t, input cmrs_cr_op_t o, input logic [7:0] dd, output int k);
    cr = '{1'b1, t, o, dd};
    @(negedge clk);
    cr.en = 1'b0;
    k = 0;
    repeat (5)
    begin
      k += int'(int_block === 1'b1);
      @(negedge clk);
    end
  endtask

  function automatic logic [7:0] addf(input logic [7:0] x, input logic [7:0] y);
    logic [8:0] t;
    t = x + y;
    return {2'b00, x[3:0] + y[3:0] > 5'h0F, 1'b0, t[7], t[7:0] == 8'h00,
            x[7] == y[7] && t[7] != x[7], t[8]};
  endfunction

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    {rst_n, clk_en, mode_large, au_en, au_dec, mac_clr, mac_wr_hi, mac_wr_lo} = '0;
    {mac_acc, pc_ld, pc_inc, instr_done, call_req, mi_req, mi_call, exc_req} = '0;
    {exr_valid, mem_ack, au_idx, au_step, rd_idx, mi_aa, exc_idx} = '0;
    {pc_ld_addr, call_target, ea_in, mac_data, mem_rdata} = '0;
    gwr = '0;
    alu = '0;
    cr = '0;
    clk_en = 1'b1;
    miscompares = 0;
    samples_checked = 0;
    void'($urandom(29315));
    for (int m = 0; m < 2; m++)
    begin
      mode_large = m[0];
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      chk("exr_out", 32'h7F, exr_out);
      chk("ccr_mask", 32'h1, ccr_out[7]);
      chk("busy", 32'h1, busy);
      r = $urandom;
      ack(r, a, w);
      chk("vec_addr", {m[0], 24'h0}, a);
      chk("pc_reset", m ? r[23:0] : r[15:0], pc_out);
      r = $urandom;
      wr(1, CMRS_WR_WL, r);
      wr(1, CMRS_WR_BL, 32'h3C);
      wr(1, CMRS_WR_BH, 32'h5A);
      rdc(1, {r[31:16], 8'h5A, 8'h3C});
      wr(2, CMRS_WR_WL, 32'h0000FFFF);
      {au_idx, au_step, au_dec, au_en} = {3'h2, 3'h1, 1'b0, 1'b1};
      @(negedge clk);
      au_en = 1'b0;
      rdc(2, 32'h00010000);
      {au_dec, au_en} = 2'h3;
      @(negedge clk);
      au_en = 1'b0;
      rdc(2, 32'h0000FFFF);
      ea_in = $urandom;
      @(negedge clk);
      ev = m ? ea_in[23:0] : ea_in[15:0];
      chk("ea_out", ev, ea_out);
      {clk_en, ea_in} = {1'b0, ~ea_in};
      @(negedge clk);
      chk("ea_hold", ev, ea_out);
      clk_en = 1'b1;
      pa = $urandom;
      pc_ld_addr = pa | 24'h1;
      pc_ld = 1'b1;
      @(negedge clk);
      pc_ld = 1'b0;
      @(negedge clk);
      chk("fetch_addr", m ? pa & 24'hFFFFFE : pa[15:0] & 16'hFFFE, fetch_addr);
      pc_inc = 1'b1;
      @(negedge clk);
      pc_inc = 1'b0;
      pcv = pc_ld_addr + 24'h2;
      chk("pc_inc", pcv, pc_out);
      ex = 8'h7F;
      foreach (ops[k])
      begin
        d = $urandom;
        crop(1'b1, ops[k], d, nb);
        ex = ops[k] == CMRS_CR_LOAD ? d : ops[k] == CMRS_CR_AND ? ex & d :
             ops[k] == CMRS_CR_OR ? ex | d : ex ^ d;
        ex = {ex[7], 4'hF, ex[2:0]};
        chk("exr_out", ex, exr_out);
        chk("blocked", 32'h3, nb);
      end
      crop(1'b1, CMRS_CR_STORE, 8'h00, nb);
      chk("blocked", 32'h0, nb);
      chk("cr_rdata", ex, cr_rdata);
      for (int t = 0; t < 2; t++)
      begin
        crop(1'b1, CMRS_CR_LOAD, {t[0], 7'h00}, nb);
        nt = 0;
        instr_done = 1'b1;
        @(negedge clk);
        instr_done = 1'b0;
        repeat (3)
        begin
          nt += int'(trace_req === 1'b1);
          @(negedge clk);
        end
        chk("trace", t, nt);
      end
      d = $urandom & 8'h7F;
      crop(1'b0, CMRS_CR_LOAD, d, nb);
      chk("ccr_out", d, ccr_out);
      a8 = $urandom;
      b8 = (m == 0) ? 8'h01 | {4'h0, ~a8[3:0]} : $urandom;
      alu = '{1'b1, CMRS_ALU_ADD, CMRS_SZ_B, a8, b8, 1'b0, 32'h0, 1'b0};
      @(negedge clk);
      alu.en = 1'b0;
      chk("flags", addf(a8, b8), ccr_out & 8'h2F);
      chk("alu_res", {24'h0, a8 + b8}, alu_res);
      mac_data = $urandom;
      mac_wr_hi = 1'b1;
      @(negedge clk);
      mac_wr_hi = 1'b0;
      chk("accumulator_high", {{22{mac_data[9]}}, mac_data[9:0]}, accumulator_high_out);
      mv[41:32] = mac_data[9:0];
      mac_data = $urandom;
      mac_wr_lo = 1'b1;
      @(negedge clk);
      mac_wr_lo = 1'b0;
      mv[31:0] = mac_data;
      chk("accumulator_low", mv[31:0], accumulator_low_out);
      mac_data = $urandom;
      mac_acc = 1'b1;
      @(negedge clk);
      mac_acc = 1'b0;
      mv = mv + {{10{mac_data[31]}}, mac_data};
      chk("mac_acc_hi", {{22{mv[41]}}, mv[41:32]}, accumulator_high_out);
      chk("mac_acc_lo", mv[31:0], accumulator_low_out);
      mac_clr = 1'b1;
      @(negedge clk);
      mac_clr = 1'b0;
      chk("mac_clr", 32'h0, accumulator_high_out | accumulator_low_out);
      s = $urandom & 32'h00FFFFFC;
      wr(7, CMRS_WR_WL, s);
      call_target = $urandom;
      call_req = 1'b1;
      @(negedge clk);
      call_req = 1'b0;
      ack(32'h0, a, w);
      s = s - (m ? 4 : 2);
      chk("push_addr", m ? {1'b1, s[23:0]} : {9'h0, s[15:0]}, a);
      chk("push_data", m ? {8'h00, pcv} : pcv[15:0], m ? w : w[15:0]);
      chk("pc_call", call_target, pc_out);
      chk("push_we", 32'h1, wv);
      chk("busy", 32'h0, busy);
      mi_aa = $urandom;
      mi_call = m[0];
      mi_req = 1'b1;
      @(negedge clk);
      mi_req = 1'b0;
      r = $urandom;
      ack(r, a, w);
      chk("mi_addr", {m[0], 16'h0, mi_aa}, a);
      chk("mi_we", 32'h0, wv);
      if (m)
      begin
        ack(32'h0, a, w);
        s = s - 4;
        chk("mi_push_addr", {1'b1, s[23:0]}, a);
        chk("mi_push", {8'h00, call_target}, w);
      end
      chk("pc_mi", m ? r[23:0] : r[15:0], pc_out);
      exr_valid = $urandom;
      exc_idx = $urandom;
      exc_req = 1'b1;
      @(negedge clk);
      exc_req = 1'b0;
      n = (m ? 2 : 3) + exr_valid;
      r = $urandom;
      repeat (n) ack(r, a, w);
      ev = exc_idx * (m ? 4 : 2);
      chk("vec_addr", {m[0], ev}, a);
      chk("ccr_mask", 32'h1, ccr_out[7]);
      chk("pc_exc", m ? r[23:0] : r[15:0], pc_out);
      s = s - 4 - 2 * exr_valid;
      rdc(7, s);
    end
    report_and_stop();
  end
endmodule
